// ===== verilog/ssbs_top.v
// Stop, brake and motion-limit supervisor for a servo drive
//
// Overview of operation
// - Servo-off mode picks decel and after-stop action
// - Decel ends at zero speed or time limit
// - Fault brake time limit in milliseconds
// - Release brake once fault time exceeded
// - Phase loss raises alarm code 19 if enabled
// - Current jump over threshold raises code 40
// - Overspeed over 400 ms raises alarm
// - Clamp commanded rates to maximum acceleration
// - Stop and limit use maximum acceleration
// - Internal speed mode tracks signed target
// - Internal mode uses separate accel, decel
// - Jerk time smooths speed commands
// - Servo-off mode accepts 0 to 5
//
// Implementation choices: the address map and the plain strobed port.
`include "ssbs_consts.vh"
module ssbs_top #(
  parameter MS_CYCLES = `SSBS_MS_CYCLES
) (
  input  wire        sys_clk_i,
  input  wire        srst_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  input  wire [15:0] speed_fb_i,
  input  wire [15:0] current_i,
  input  wire [15:0] ext_speed_cmd_i,
  input  wire [15:0] ext_accel_i,
  input  wire        phase_loss_i,
  input  wire        limit_hit_i,
  output reg         drive_en_o,
  output reg         dyn_brake_o,
  output reg  [15:0] speed_ref_o,
  output wire        fault_o,
  output reg  [7:0]  fault_code_o
);
  localparam [5:0] S_RUN   = 6'h01;
  localparam [5:0] S_OFFD  = 6'h02;
  localparam [5:0] S_OFFS  = 6'h04;
  localparam [5:0] S_ERRD  = 6'h08;
  localparam [5:0] S_ERRS  = 6'h10;
  localparam [5:0] S_IDLE  = 6'h20;
  localparam [31:0] MS_TOP = MS_CYCLES - 1;

  reg [2:0]  servo_off_brake_mode;
  reg [1:0]  error_brake_mode;
  reg [15:0] servo_off_brake_time;
  reg [15:0] error_brake_time;
  reg [15:0] zero_speed_threshold;
  reg        phase_loss_detect_enable;
  reg [15:0] current_jump_threshold;
  reg [15:0] max_speed_limit;
  reg [15:0] max_accel_limit;
  reg [15:0] internal_speed_target;
  reg [15:0] internal_speed_accel;
  reg [15:0] internal_speed_decel;
  reg [7:0]  jerk_smoothing_time;
  reg [2:0]  ctrl;
  reg [2:0]  alarm;
  reg [5:0]  state;
  reg [5:0]  next_state;
  reg [31:0] ms_cnt;
  reg        ms_tick;
  reg [15:0] brake_ms;
  reg        err_timeout;
  reg [1:0]  phase_sync;
  reg [1:0]  limit_sync;
  reg [15:0] prev_cur;
  reg        cur_valid;
  reg [8:0]  ovs_ms;
  reg signed [23:0] ramp;
  reg signed [23:0] smooth;

  wire        wr_clr = reg_wr_i && (reg_addr_i == `SSBS_A_ALM_CLR);
  wire [2:0]  clr_bits = wr_clr ? reg_wdata_i[2:0] : 3'h0;
  wire [15:0] abs_spd = speed_fb_i[15] ? (16'h0000 - speed_fb_i)
                                       : speed_fb_i;
  wire        at_zero = abs_spd <= zero_speed_threshold;
  wire [15:0] cur_diff = (current_i >= prev_cur) ? (current_i - prev_cur)
                                                 : (prev_cur - current_i);
  wire        servo_on = ctrl[`SSBS_CTRL_SERVO];
  wire        is_mode = ctrl[`SSBS_CTRL_ISMODE];
  wire        hard_stop = ctrl[`SSBS_CTRL_ESTOP] | limit_sync[1];
  wire        soff_done = at_zero || (brake_ms >= servo_off_brake_time);
  wire        err_late = brake_ms >= error_brake_time;
  wire [2:0]  new_alarm;

  assign fault_o = |alarm;

  // Register writes
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      servo_off_brake_mode     <= `SSBS_R_SOFF_MODE;
      error_brake_mode         <= `SSBS_R_ERR_MODE;
      servo_off_brake_time     <= `SSBS_R_SOFF_TIME;
      error_brake_time         <= `SSBS_R_ERR_TIME;
      zero_speed_threshold     <= `SSBS_R_ZERO_SPD;
      phase_loss_detect_enable <= 1'b0;
      current_jump_threshold   <= `SSBS_R_CUR_JUMP;
      max_speed_limit          <= `SSBS_R_MAX_SPD;
      max_accel_limit          <= `SSBS_R_MAX_ACC;
      internal_speed_target    <= `SSBS_R_IS_TGT;
      internal_speed_accel     <= `SSBS_R_IS_ACC;
      internal_speed_decel     <= `SSBS_R_IS_DEC;
      jerk_smoothing_time      <= `SSBS_R_JERK;
      ctrl                     <= 3'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `SSBS_A_SOFF_MODE: begin
          if (reg_wdata_i[2:0] <= 3'h5) begin
            servo_off_brake_mode <= reg_wdata_i[2:0];
          end
        end
        `SSBS_A_ERR_MODE:  error_brake_mode <= reg_wdata_i[1:0];
        `SSBS_A_SOFF_TIME: servo_off_brake_time <= reg_wdata_i[15:0];
        `SSBS_A_ERR_TIME:  error_brake_time <= reg_wdata_i[15:0];
        `SSBS_A_ZERO_SPD:  zero_speed_threshold <= reg_wdata_i[15:0];
        `SSBS_A_PHASE_EN:  phase_loss_detect_enable <= reg_wdata_i[0];
        `SSBS_A_CUR_JUMP:  current_jump_threshold <= reg_wdata_i[15:0];
        `SSBS_A_MAX_SPD:   max_speed_limit <= reg_wdata_i[15:0];
        `SSBS_A_MAX_ACC:   max_accel_limit <= reg_wdata_i[15:0];
        `SSBS_A_IS_TGT:    internal_speed_target <= reg_wdata_i[15:0];
        `SSBS_A_IS_ACC:    internal_speed_accel <= reg_wdata_i[15:0];
        `SSBS_A_IS_DEC:    internal_speed_decel <= reg_wdata_i[15:0];
        `SSBS_A_JERK:      jerk_smoothing_time <= reg_wdata_i[7:0];
        `SSBS_A_CTRL:      ctrl <= reg_wdata_i[2:0];
        default: ;
      endcase
    end
  end

  // Register reads, answer one cycle later
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SSBS_A_SOFF_MODE: reg_rdata_o <= {29'h0, servo_off_brake_mode};
        `SSBS_A_ERR_MODE:  reg_rdata_o <= {30'h0, error_brake_mode};
        `SSBS_A_SOFF_TIME: reg_rdata_o <= {16'h0, servo_off_brake_time};
        `SSBS_A_ERR_TIME:  reg_rdata_o <= {16'h0, error_brake_time};
        `SSBS_A_ZERO_SPD:  reg_rdata_o <= {16'h0, zero_speed_threshold};
        `SSBS_A_PHASE_EN:  reg_rdata_o <= {31'h0, phase_loss_detect_enable};
        `SSBS_A_CUR_JUMP:  reg_rdata_o <= {16'h0, current_jump_threshold};
        `SSBS_A_MAX_SPD:   reg_rdata_o <= {16'h0, max_speed_limit};
        `SSBS_A_MAX_ACC:   reg_rdata_o <= {16'h0, max_accel_limit};
        `SSBS_A_IS_TGT:    reg_rdata_o <= {16'h0, internal_speed_target};
        `SSBS_A_IS_ACC:    reg_rdata_o <= {16'h0, internal_speed_accel};
        `SSBS_A_IS_DEC:    reg_rdata_o <= {16'h0, internal_speed_decel};
        `SSBS_A_JERK:      reg_rdata_o <= {24'h0, jerk_smoothing_time};
        `SSBS_A_CTRL:      reg_rdata_o <= {29'h0, ctrl};
        `SSBS_A_STATUS:    reg_rdata_o <= {8'h0, fault_code_o, 2'h0,
                                           state, 5'h0, alarm};
        `SSBS_A_SPD_REF:   reg_rdata_o <= {16'h0, speed_ref_o};
        default:           reg_rdata_o <= 32'h00000000;
      endcase
    end
  end

  // Millisecond tick and input synchronisers
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ms_cnt     <= 32'h00000000;
      ms_tick    <= 1'b0;
      phase_sync <= 2'h0;
      limit_sync <= 2'h0;
    end else begin
      ms_tick    <= (ms_cnt == MS_TOP);
      ms_cnt     <= (ms_cnt == MS_TOP) ? 32'h00000000 : ms_cnt + 32'h1;
      phase_sync <= {phase_sync[0], phase_loss_i};
      limit_sync <= {limit_sync[0], limit_hit_i};
    end
  end

  assign new_alarm[`SSBS_ALM_PHASE] = phase_loss_detect_enable &
                                      phase_sync[1];
  assign new_alarm[`SSBS_ALM_COLL] = ms_tick & cur_valid &
    (cur_diff > current_jump_threshold);
  assign new_alarm[`SSBS_ALM_OVS] = ms_tick &
    (abs_spd > max_speed_limit) &
    (ovs_ms == `SSBS_OVS_MS);

  // Alarm detection and latching; a new alarm beats a clear
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      alarm        <= 3'h0;
      fault_code_o <= 8'h00;
      prev_cur     <= 16'h0000;
      cur_valid    <= 1'b0;
      ovs_ms       <= 9'h000;
    end else begin
      alarm <= (alarm & ~clr_bits) | new_alarm;
      if (ms_tick) begin
        prev_cur  <= current_i;
        cur_valid <= 1'b1;
        if (abs_spd <= max_speed_limit) begin
          ovs_ms <= 9'h000;
        end else if (ovs_ms != `SSBS_OVS_MS) begin
          ovs_ms <= ovs_ms + 9'h001;
        end
      end
      if (!fault_o || ((alarm & ~clr_bits) == 3'h0)) begin
        if (new_alarm[`SSBS_ALM_PHASE]) begin
          fault_code_o <= `SSBS_CODE_PHASE;
        end else if (new_alarm[`SSBS_ALM_COLL]) begin
          fault_code_o <= `SSBS_CODE_COLL;
        end else if (new_alarm[`SSBS_ALM_OVS]) begin
          fault_code_o <= `SSBS_CODE_OVS;
        end else if (fault_o) begin
          fault_code_o <= 8'h00;
        end
      end
    end
  end

  // Stop and brake sequencing
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (servo_on) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (!servo_on) begin
          next_state = S_OFFD;
        end
      end
      S_OFFD: begin
        if (soff_done) begin
          next_state = S_OFFS;
        end
      end
      S_OFFS: begin
        if (servo_on) begin
          next_state = S_RUN;
        end
      end
      S_ERRD: begin
        if (at_zero || err_late) begin
          next_state = S_ERRS;
        end
      end
      S_ERRS: begin
        if (!fault_o) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (fault_o && (state != S_ERRD) && (state != S_ERRS)) begin
      next_state = S_ERRD;
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      state       <= S_IDLE;
      brake_ms    <= 16'h0000;
      err_timeout <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        brake_ms <= 16'h0000;
      end else if (ms_tick && (brake_ms != 16'hFFFF)) begin
        brake_ms <= brake_ms + 16'h0001;
      end
      if (state == S_ERRD) begin
        err_timeout <= !at_zero && err_late;
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      drive_en_o  <= 1'b0;
      dyn_brake_o <= 1'b0;
    end else begin
      case (next_state)
        S_RUN: begin
          drive_en_o  <= 1'b1;
          dyn_brake_o <= 1'b0;
        end
        S_OFFD: begin
          drive_en_o  <= servo_off_brake_mode[2:1] == 2'h0;
          dyn_brake_o <= servo_off_brake_mode[2];
        end
        S_OFFS: begin
          drive_en_o  <= 1'b0;
          dyn_brake_o <= servo_off_brake_mode[0];
        end
        S_ERRD: begin
          drive_en_o  <= 1'b0;
          dyn_brake_o <= error_brake_mode[1];
        end
        S_ERRS: begin
          drive_en_o  <= 1'b0;
          dyn_brake_o <= error_brake_mode[0] &
            !(state == S_ERRD ? (!at_zero && err_late)
                              : err_timeout);
        end
        default: begin
          drive_en_o  <= 1'b0;
          dyn_brake_o <= 1'b0;
        end
      endcase
    end
  end

  // Speed ramp in units of raw speed times 25, one step per ms
  reg  [15:0] tgt_raw;
  reg  [15:0] acc_cmd;
  reg  [15:0] dec_cmd;
  reg  [3:0]  jerk_shift;
  reg  [15:0] rate;
  integer     i;
  wire signed [23:0] tgt_ext = {{8{tgt_raw[15]}}, tgt_raw};
  wire signed [23:0] tgt25 = (tgt_ext <<< 4) + (tgt_ext <<< 3) + tgt_ext;
  wire signed [23:0] diff = tgt25 - ramp;
  wire signed [23:0] step = {8'h00, rate};
  wire signed [23:0] sm_next = smooth + ((ramp - smooth) >>> jerk_shift);
  wire signed [23:0] ref_q = smooth / `SSBS_SPD_SCALE;
  wire        away = ramp[23] ? (diff[23]) : (!diff[23]);

  always @* begin
    if (is_mode) begin
      tgt_raw = internal_speed_target;
      acc_cmd = internal_speed_accel;
      dec_cmd = internal_speed_decel;
    end else begin
      tgt_raw = ext_speed_cmd_i;
      acc_cmd = ext_accel_i;
      dec_cmd = ext_accel_i;
    end
    rate = away ? acc_cmd : dec_cmd;
    if (rate > max_accel_limit) begin
      rate = max_accel_limit;
    end
    if (state != S_RUN || hard_stop) begin
      tgt_raw = 16'h0000;
      rate = max_accel_limit;
    end
    jerk_shift = 4'h0;
    for (i = 0; i < 8; i = i + 1) begin
      if (jerk_smoothing_time[i]) begin
        jerk_shift = i[3:0] + 4'h1;
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ramp        <= 24'sh000000;
      smooth      <= 24'sh000000;
      speed_ref_o <= 16'h0000;
    end else begin
      speed_ref_o <= ref_q[15:0];
      if (!drive_en_o) begin
        ramp   <= 24'sh000000;
        smooth <= 24'sh000000;
      end else if (ms_tick) begin
        if (diff > step) begin
          ramp <= ramp + step;
        end else if (diff < -step) begin
          ramp <= ramp - step;
        end else begin
          ramp <= tgt25;
        end
        smooth <= sm_next;
      end
    end
  end
endmodule

// ===== shared/ssbs_consts.vh
// Constants for the stop, brake and motion-limit supervisor
`ifndef SSBS_CONSTS_VH
`define SSBS_CONSTS_VH
`define SSBS_CLK_NS        5
`define SSBS_MS_NS         1000000
`define SSBS_MS_CYCLES     (`SSBS_MS_NS / `SSBS_CLK_NS)
`define SSBS_OVS_MS        400
`define SSBS_SPD_SCALE     24'sd25
`define SSBS_A_SOFF_MODE   8'h00
`define SSBS_A_ERR_MODE    8'h04
`define SSBS_A_SOFF_TIME   8'h08
`define SSBS_A_ERR_TIME    8'h0C
`define SSBS_A_ZERO_SPD    8'h10
`define SSBS_A_PHASE_EN    8'h14
`define SSBS_A_CUR_JUMP    8'h18
`define SSBS_A_MAX_SPD     8'h1C
`define SSBS_A_MAX_ACC     8'h20
`define SSBS_A_IS_TGT      8'h24
`define SSBS_A_IS_ACC      8'h28
`define SSBS_A_IS_DEC      8'h2C
`define SSBS_A_JERK        8'h30
`define SSBS_A_CTRL        8'h34
`define SSBS_A_ALM_CLR     8'h38
`define SSBS_A_STATUS      8'h3C
`define SSBS_A_SPD_REF     8'h40
`define SSBS_CTRL_SERVO    0
`define SSBS_CTRL_ISMODE   1
`define SSBS_CTRL_ESTOP    2
`define SSBS_ALM_PHASE     0
`define SSBS_ALM_COLL      1
`define SSBS_ALM_OVS       2
`define SSBS_R_SOFF_MODE   3'h0
`define SSBS_R_ERR_MODE    2'h0
`define SSBS_R_SOFF_TIME   16'h01F4
`define SSBS_R_ERR_TIME    16'h01F4
`define SSBS_R_ZERO_SPD    16'h0030
`define SSBS_R_CUR_JUMP    16'h03E8
`define SSBS_R_MAX_SPD     16'h4B00
`define SSBS_R_MAX_ACC     16'h4650
`define SSBS_R_IS_TGT      16'h0960
`define SSBS_R_IS_ACC      16'h0258
`define SSBS_R_IS_DEC      16'h0258
`define SSBS_R_JERK        8'h0A
`define SSBS_CODE_PHASE    8'h13
`define SSBS_CODE_COLL     8'h28
`define SSBS_CODE_OVS      8'h0C
`endif

// ===== sim/ssbs_properties.sv
// Port-level checks for the stop and brake supervisor
module ssbs_props #(
  parameter MS_CYCLES = 200000
) (
  input wire        sys_clk_i,
  input wire        srst_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire [15:0] speed_fb_i,
  input wire [15:0] current_i,
  input wire [15:0] ext_speed_cmd_i,
  input wire [15:0] ext_accel_i,
  input wire        phase_loss_i,
  input wire        limit_hit_i,
  input wire        drive_en_o,
  input wire        dyn_brake_o,
  input wire [15:0] speed_ref_o,
  input wire        fault_o,
  input wire [7:0]  fault_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg         [15:0] ref_q;
  wire signed [16:0] ref_step;
  always @(posedge sys_clk_i) begin
    ref_q <= speed_ref_o;
  end
  assign ref_step = $signed({speed_ref_o[15], speed_ref_o})
                  - $signed({ref_q[15], ref_q});
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  property p_clr_reads_zero;
    reg_rd_i && reg_addr_i == 8'h38 |=> reg_rdata_o == 32'h0;
  endproperty
  a_clr_reads_zero: assert property (p_clr_reads_zero)
    else $error("alarm clear register read not zero");
  property p_mode_range;
    reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o <= 32'h5;
  endproperty
  a_mode_range: assert property (p_mode_range)
    else $error("servo-off brake mode out of range");
  property p_code_valid;
    $rose(fault_o) |-> ##[0:2] fault_code_o inside {8'h13, 8'h28, 8'h0C};
  endproperty
  a_code_valid: assert property (p_code_valid)
    else $error("fault code not a known alarm code");
  property p_fault_cut;
    fault_o [*3] |-> !drive_en_o;
  endproperty
  a_fault_cut: assert property (p_fault_cut)
    else $error("drive still enabled under alarm");
  property p_alarm_hold;
    fault_o && !(reg_wr_i && reg_addr_i == 8'h38) |=> fault_o;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm dropped without clear");
  property p_brake_excl;
    dyn_brake_o |-> !drive_en_o;
  endproperty
  a_brake_excl: assert property (p_brake_excl)
    else $error("brake and drive both on");
  property p_ref_idle;
    !drive_en_o && !$past(drive_en_o) && !$past(drive_en_o, 2)
      |-> speed_ref_o == 16'h0;
  endproperty
  a_ref_idle: assert property (p_ref_idle)
    else $error("speed reference not zero while idle");
  property p_ramp;
    drive_en_o && $past(drive_en_o)
      |-> ref_step >= -17'sd720 && ref_step <= 17'sd720;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("speed reference step above maximum rate");
endmodule

bind ssbs_top ssbs_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .speed_fb_i(speed_fb_i),
  .current_i(current_i), .ext_speed_cmd_i(ext_speed_cmd_i),
  .ext_accel_i(ext_accel_i), .phase_loss_i(phase_loss_i),
  .limit_hit_i(limit_hit_i), .drive_en_o(drive_en_o),
  .dyn_brake_o(dyn_brake_o), .speed_ref_o(speed_ref_o),
  .fault_o(fault_o), .fault_code_o(fault_code_o)
);

// ===== sim/ssbs_motor.sv
// Motor and power stage stand-in, speed in raw rps*240 units
module ssbs_motor (
  input  wire        sys_clk_i,
  input  wire        drive_en_i,
  input  wire        dyn_brake_i,
  input  wire [15:0] speed_ref_i,
  input  wire        stuck_i,
  input  wire        ovs_i,
  output reg  [15:0] speed_fb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire signed [15:0] sfb = speed_fb_o;
  initial speed_fb_o = 16'h0000;
  always @(posedge sys_clk_i) begin
    if (ovs_i)
      speed_fb_o <= 16'h4E20;
    else if (drive_en_i)
      speed_fb_o <= speed_ref_i;
    else if (stuck_i)
      speed_fb_o <= speed_fb_o;
    else if (sfb > 16'sd8)
      speed_fb_o <= sfb - (sfb >>> (dyn_brake_i ? 3 : 6)) - 16'sd1;
    else
      speed_fb_o <= 16'h0000;
  end
endmodule

// ===== sim/test_ssbs_top.sv
// Self-checking bench for the stop and brake supervisor
`include "ssbs_consts.vh"
module test_ssbs_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam MS = 20;
  reg         sys_clk_i = 1'b0;
  reg         srst_i = 1'b1;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg  [15:0] cur = 16'h0000;
  reg  [15:0] ext_acc = 16'h7530;
  reg         ph = 1'b0;
  reg         lim = 1'b0;
  reg         stuck = 1'b0;
  reg         ovs = 1'b0;
  reg  [31:0] v;
  wire [31:0] rdata;
  wire [15:0] fb, sref;
  wire        drv, brk, flt;
  wire [7:0]  code;
  int         n_mismatch = 0;
  int         n_tests = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  ssbs_top #(.MS_CYCLES(MS)) dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .speed_fb_i(fb), .current_i(cur), .ext_speed_cmd_i(16'h0960),
    .ext_accel_i(ext_acc), .phase_loss_i(ph), .limit_hit_i(lim),
    .drive_en_o(drv), .dyn_brake_o(brk), .speed_ref_o(sref),
    .fault_o(flt), .fault_code_o(code));
  ssbs_motor u_motor (
    .sys_clk_i(sys_clk_i), .drive_en_i(drv), .dyn_brake_i(brk),
    .speed_ref_i(sref), .stuck_i(stuck), .ovs_i(ovs), .speed_fb_o(fb));
  task summarize;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string what, input [31:0] seen, input [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i) wr <= 1'b0;
  endtask
  task rreg(input [7:0] a);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i) rd <= 1'b0;
    #1 v = rdata;
  endtask
  task wstate(input [5:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      rreg(`SSBS_A_STATUS);
      if (v[13:8] === s)
        return;
    end
    chk("state", v[13:8], s);
    summarize;
  endtask
  task wflt(input int n);
    for (int i = 0; i < n && flt !== 1'b1; i++)
      cyc(1);
    chk("fault", flt, 1'b1);
    if (flt !== 1'b1)
      summarize;
  endtask
  task clr;
    wreg(`SSBS_A_CTRL, 32'h0);
    wreg(`SSBS_A_ALM_CLR, 32'h7);
    wstate(6'h20, 400);
    chk("cleared", flt, 1'b0);
    chk("code cleared", code, 8'h00);
  endtask
  task t_regs;
    logic [7:0] a[9] = '{8'h08, 8'h0C, 8'h18, 8'h1C, 8'h20, 8'h24,
                         8'h28, 8'h2C, 8'h30};
    int e[9] = '{500, 500, 1000, 80 * 240, 3000 * 6, 10 * 240,
                 100 * 6, 100 * 6, 10};
    for (int i = 0; i < 9; i++) begin
      rreg(a[i]);
      chk("default", v, e[i]);
    end
    wreg(`SSBS_A_SOFF_MODE, 32'h6);
    rreg(`SSBS_A_SOFF_MODE);
    chk("mode", v, 32'h0);
    rreg(`SSBS_A_PHASE_EN);
    chk("phase en", v, 32'h0);
    rreg(8'hFC);
    chk("unmapped", v, 32'h0);
    rreg(`SSBS_A_ALM_CLR);
    chk("clear reads", v, 32'h0);
    $display("register test done");
  endtask
  task t_phase_off;
    @(posedge sys_clk_i) ph <= 1'b1;
    cyc(5 * MS);
    chk("phase off", flt, 1'b0);
    @(posedge sys_clk_i) ph <= 1'b0;
    wreg(`SSBS_A_PHASE_EN, 32'h1);
    rreg(`SSBS_A_PHASE_EN);
    chk("phase en set", v, 32'h1);
    $display("phase detect off test done");
  endtask
  task t_soff_time;
    wreg(`SSBS_A_SOFF_TIME, 32'd3);
    wreg(`SSBS_A_SOFF_MODE, 32'h4);
    wreg(`SSBS_A_CTRL, 32'h1);
    cyc(20 * MS);
    @(posedge sys_clk_i) stuck <= 1'b1;
    wreg(`SSBS_A_CTRL, 32'h0);
    cyc(2);
    chk("hold brake", brk, 1'b1);
    wstate(6'h04, 40);
    chk("held speed", fb, 16'h0960);
    chk("time stop brake", brk, 1'b0);
    @(posedge sys_clk_i) stuck <= 1'b0;
    $display("servo-off time limit test done");
  endtask
  task t_soff(input [2:0] m);
    wreg(`SSBS_A_SOFF_MODE, m);
    wreg(`SSBS_A_CTRL, 32'h1);
    cyc(40 * MS);
    chk("run ref", sref, 16'h0960);
    wreg(`SSBS_A_CTRL, 32'h0);
    cyc(2);
    chk("decel drive", drv, m < 2);
    chk("decel brake", brk, m > 3);
    wstate(6'h04, 400);
    chk("stop brake", brk, m[0]);
    $display("servo-off mode %0d done", m);
  endtask
  task t_err(input [1:0] m, input stk);
    wreg(`SSBS_A_ERR_MODE, m);
    wreg(`SSBS_A_CTRL, 32'h1);
    cyc(20 * MS);
    @(posedge sys_clk_i) stuck <= stk;
    ph <= 1'b1;
    wflt(3 * MS);
    @(posedge sys_clk_i) ph <= 1'b0;
    cyc(2);
    chk("phase code", code, 8'h13);
    chk("err drive", drv, 1'b0);
    chk("err brake", brk, m[1]);
    wstate(6'h10, stk ? 40 : 400);
    chk("stop brake", brk, m[0] & !stk);
    @(posedge sys_clk_i) stuck <= 1'b0;
    clr;
    $display("error mode %0d stuck %0d done", m, stk);
  endtask
  task t_coll;
    @(posedge sys_clk_i) cur <= 16'd1000;
    cyc(3 * MS);
    @(posedge sys_clk_i) cur <= 16'd0;
    cyc(3 * MS);
    chk("no jump alarm", flt, 1'b0);
    @(posedge sys_clk_i) cur <= 16'd1001;
    wflt(3 * MS);
    chk("jump code", code, 8'h28);
    clr;
    $display("collision test done");
  endtask
  task t_ovs;
    @(posedge sys_clk_i) ovs <= 1'b1;
    cyc(398 * MS);
    chk("early overspeed", flt, 1'b0);
    wflt(5 * MS);
    chk("overspeed code", code, 8'h0C);
    @(posedge sys_clk_i) ovs <= 1'b0;
    clr;
    $display("overspeed test done");
  endtask
  task t_isp;
    wreg(`SSBS_A_IS_TGT, 2 * 240);
    wreg(`SSBS_A_IS_DEC, 200 * 6);
    wreg(`SSBS_A_CTRL, 32'h3);
    cyc(10 * MS);
    chk("accel", sref >= 16'd192 && sref <= 16'd264, 1'b1);
    cyc(20 * MS);
    chk("target", sref, 16'd480);
    wreg(`SSBS_A_IS_TGT, 32'h0000FE20);
    cyc(5 * MS);
    chk("decel", sref >= 16'd288 && sref <= 16'd336, 1'b1);
    cyc(40 * MS);
    chk("neg target", sref, 16'hFE20);
    wreg(`SSBS_A_CTRL, 32'h7);
    cyc(5 * MS);
    chk("estop stop", sref, 16'h0000);
    wreg(`SSBS_A_CTRL, 32'h3);
    cyc(25 * MS);
    chk("estop resume", sref, 16'hFE20);
    @(posedge sys_clk_i) lim <= 1'b1;
    cyc(5 * MS);
    chk("limit stop", sref, 16'h0000);
    @(posedge sys_clk_i) lim <= 1'b0;
    wreg(`SSBS_A_CTRL, 32'h0);
    $display("internal speed test done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_regs;
    wreg(`SSBS_A_JERK, 32'h0);
    t_phase_off;
    for (int m = 0; m < 6; m++)
      t_soff(m[2:0]);
    t_soff_time;
    for (int m = 0; m < 4; m++)
      t_err(m[1:0], 1'b0);
    wreg(`SSBS_A_ERR_TIME, 32'd3);
    t_err(2'h3, 1'b1);
    t_coll;
    t_ovs;
    t_isp;
    summarize;
  end
endmodule
